//--- hw/rbf_top.sv
`timescale 1ns/10ps
// Rotate, bit transfer and flag operations behind an Avalon-MM slave
module rbf_top (
  input wire logic ref_clk,             // 20 MHz clock
  input wire logic rst_n,               // Synchronous reset, active low
  input wire logic [3:0] avs_address,   // Byte address
  input wire logic avs_read,            // Read request
  input wire logic avs_write,           // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata,     // Read data, registered
  output logic avs_waitrequest,         // Stall until answer
  output logic [1:0] avs_response,      // 00 ok, 10 slave error
  output logic [7:0] status_flags_register, // Live status flags
  output logic sleep_pulse,             // One-cycle sleep request
  output logic watchdog_restart_pulse   // One-cycle watchdog restart
);
  logic [7:0] flags_reg, flags_next;
  logic [7:0] work_reg, work_next;
  logic [1:0] evt_reg, evt_next;
  logic ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] resp_reg, resp_next;
  logic slp_reg, slp_next, dog_reg, dog_next;
  logic [7:0] ex_work, ex_flags;
  logic ex_sleep, ex_dog, go, mapped;

  ////////////////////////////////////////////////////////////////
  // Execution datapath; a write to the command register issues one op
  rbf_exec u_exec (
    .op(avs_writedata[rbf_pkg::CMD_OP_LSB +: rbf_pkg::CMD_OP_W]),
    .bit_sel(avs_writedata[rbf_pkg::CMD_BIT_LSB +: rbf_pkg::CMD_BIT_W]),
    .work_in(work_reg),
    .flags_in(flags_reg),
    .work_out(ex_work),
    .flags_out(ex_flags),
    .sleep_req(ex_sleep),
    .watchdog_req(ex_dog)
  );

  ////////////////////////////////////////////////////////////////
  // Every access answers one cycle after it is presented
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  // A write acts only at the edge that ends its waitrequest-low cycle
  assign go = avs_write & ack_reg & avs_byteenable[0];
  assign mapped = (avs_address == rbf_pkg::ADDR_STATUS) || (avs_address == rbf_pkg::ADDR_WORK) ||
                  (avs_address == rbf_pkg::ADDR_CMD) || (avs_address == rbf_pkg::ADDR_EVENTS);

  // Next state: bus writes, execution, sticky event bits
  always_comb begin
    flags_next = flags_reg;
    work_next = work_reg;
    evt_next = evt_reg;
    ack_next = (avs_read | avs_write) & ~ack_reg;
    rdata_next = rdata_reg;
    resp_next = mapped ? 2'h0 : 2'h2;
    slp_next = 1'b0;
    dog_next = 1'b0;
    if (go && avs_address == rbf_pkg::ADDR_STATUS) begin
      flags_next = avs_writedata[7:0];
    end
    if (go && avs_address == rbf_pkg::ADDR_WORK) begin
      work_next = avs_writedata[7:0];
    end
    if (go && avs_address == rbf_pkg::ADDR_EVENTS) begin
      evt_next = evt_reg & ~avs_writedata[1:0]; // Write one to clear
    end
    if (go && avs_address == rbf_pkg::ADDR_CMD) begin
      work_next = ex_work;
      flags_next = ex_flags;
      slp_next = ex_sleep;
      dog_next = ex_dog;
    end
    // Set wins over a clear in the same cycle
    if (slp_next) begin
      evt_next[rbf_pkg::EVT_SLEEP] = 1'b1;
    end
    if (dog_next) begin
      evt_next[rbf_pkg::EVT_WATCHDOG] = 1'b1;
    end
    if (avs_read & ~ack_reg) begin
      unique case (avs_address)
        rbf_pkg::ADDR_STATUS: rdata_next = {24'h000000, flags_reg};
        rbf_pkg::ADDR_WORK: rdata_next = {24'h000000, work_reg};
        rbf_pkg::ADDR_EVENTS: rdata_next = {30'h00000000, evt_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  // Registers only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flags_reg <= rbf_pkg::STATUS_RESET;
      work_reg <= rbf_pkg::WORK_RESET;
      evt_reg <= 2'h0;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      resp_reg <= 2'h0;
      slp_reg <= 1'b0;
      dog_reg <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      work_reg <= work_next;
      evt_reg <= evt_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      resp_reg <= resp_next;
      slp_reg <= slp_next;
      dog_reg <= dog_next;
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_response = resp_reg;
  assign status_flags_register = flags_reg;
  assign sleep_pulse = slp_reg;
  assign watchdog_restart_pulse = dog_reg;

  ////////////////////////////////////////////////////////////////
  // Checks
  a_rotl_result: assert property (@(posedge ref_clk) disable iff (!rst_n)
    go && avs_address == rbf_pkg::ADDR_CMD && avs_writedata[3:0] == 4'h1 |=>
    work_reg == {$past(work_reg[6:0]), $past(flags_reg[0])} && flags_reg[0] == $past(work_reg[7]))
    else $error("rotate left wrong");
  a_rotr_result: assert property (@(posedge ref_clk) disable iff (!rst_n)
    go && avs_address == rbf_pkg::ADDR_CMD && avs_writedata[3:0] == 4'h2 |=>
    work_reg == {$past(flags_reg[0]), $past(work_reg[7:1])} && flags_reg[0] == $past(work_reg[0]))
    else $error("rotate right wrong");
  a_tflag_store: assert property (@(posedge ref_clk) disable iff (!rst_n)
    go && avs_address == rbf_pkg::ADDR_CMD && avs_writedata[3:0] == 4'h3 |=>
    flags_reg[6] == $past(work_reg[avs_writedata[6:4]]) && flags_reg[5:0] == $past(flags_reg[5:0]))
    else $error("bit store wrong");
  a_tflag_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    go && avs_address == rbf_pkg::ADDR_CMD && avs_writedata[3:0] == 4'h4 |=>
    $stable(flags_reg) && work_reg[$past(avs_writedata[6:4])] == flags_reg[6])
    else $error("bit load wrong");
  a_half_set_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    go && avs_address == rbf_pkg::ADDR_CMD && avs_writedata[3:0] == 4'h5 |=>
    flags_reg == ($past(flags_reg) | 8'h20))
    else $error("half carry set wrong");
  a_clv_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    go && avs_address == rbf_pkg::ADDR_CMD && avs_writedata[3:0] == 4'h8 |=>
    flags_reg == ($past(flags_reg) & 8'hf7))
    else $error("overflow clear wrong");
  a_sign_set_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    go && avs_address == rbf_pkg::ADDR_CMD && avs_writedata[3:0] == 4'h9 |=>
    flags_reg == ($past(flags_reg) | 8'h10))
    else $error("sign set wrong");
  a_sleep_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    go && avs_address == rbf_pkg::ADDR_CMD && avs_writedata[3:0] == 4'hd |=>
    sleep_pulse && $stable(flags_reg) ##1 !sleep_pulse)
    else $error("sleep pulse wrong");
  a_dog_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    go && avs_address == rbf_pkg::ADDR_CMD && avs_writedata[3:0] == 4'he |=>
    watchdog_restart_pulse && $stable(flags_reg))
    else $error("watchdog restart wrong");
  a_irq_off_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    go && avs_address == rbf_pkg::ADDR_CMD && avs_writedata[3:0] == 4'hc |=>
    flags_reg == ($past(flags_reg) & 8'h7f))
    else $error("interrupt disable wrong");
endmodule

//--- hw/rbf_pkg.sv
package rbf_pkg;
  // Status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] WORK_RESET = 8'h00;
  // Register map, word aligned byte addresses
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_WORK = 4'h4;
  localparam logic [3:0] ADDR_CMD = 4'h8;
  localparam logic [3:0] ADDR_EVENTS = 4'hc;
  // Command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_OP_W = 4;
  localparam int CMD_BIT_LSB = 4;
  localparam int CMD_BIT_W = 3;
  localparam int EVT_SLEEP = 0;
  localparam int EVT_WATCHDOG = 1;

  typedef enum logic [3:0] {
    OP_NOP, OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY, OP_BIT_TO_TFLAG, OP_TFLAG_TO_BIT,
    OP_HALF_CARRY_SET, OP_HALF_CARRY_CLEAR, OP_OVERFLOW_SET, OP_OVERFLOW_CLEAR,
    OP_SIGN_FLAG_SET, OP_SIGN_FLAG_CLEAR, OP_GLOBAL_IRQ_ENABLE, OP_GLOBAL_IRQ_DISABLE,
    OP_SLEEP, OP_WATCHDOG_RESTART
  } rbf_op_t;
endpackage

//--- hw/rbf_exec.sv
`timescale 1ns/10ps
// Single-cycle combinational execution of one operation
module rbf_exec (
  input wire logic [3:0] op,       // Operation code
  input wire logic [2:0] bit_sel,  // Bit index for bit transfer
  input wire logic [7:0] work_in,  // Working register value
  input wire logic [7:0] flags_in, // Status flags before
  output logic [7:0] work_out,     // Working register after
  output logic [7:0] flags_out,    // Status flags after
  output logic sleep_req,          // Sleep request
  output logic watchdog_req        // Watchdog restart request
);
  logic [7:0] res;

  // Flag update shared by both rotates
  function automatic logic [7:0] rot_flags(input logic [7:0] f, input logic [7:0] r, input logic c);
    logic [7:0] o;
    o = f;
    o[rbf_pkg::FLAG_C] = c;
    o[rbf_pkg::FLAG_Z] = (r == 8'h00);
    o[rbf_pkg::FLAG_N] = r[7];
    o[rbf_pkg::FLAG_V] = r[7] ^ c;
    o[rbf_pkg::FLAG_S] = r[7] ^ r[7] ^ c;
    return o;
  endfunction

  ////////////////////////////////////////////////////////////////
  // Default: no change; each single-flag case touches only its own flag, rotates update C, Z, N, V and S
  always_comb begin
    work_out = work_in;
    flags_out = flags_in;
    sleep_req = 1'b0;
    watchdog_req = 1'b0;
    res = 8'h00;
    unique case (op)
      rbf_pkg::OP_ROTATE_LEFT_CARRY: begin
        res = {work_in[6:0], flags_in[rbf_pkg::FLAG_C]};
        work_out = res;
        flags_out = rot_flags(flags_in, res, work_in[7]);
      end
      rbf_pkg::OP_ROTATE_RIGHT_CARRY: begin
        res = {flags_in[rbf_pkg::FLAG_C], work_in[7:1]};
        work_out = res;
        flags_out = rot_flags(flags_in, res, work_in[0]);
      end
      rbf_pkg::OP_BIT_TO_TFLAG: flags_out[rbf_pkg::FLAG_T] = work_in[bit_sel];
      rbf_pkg::OP_TFLAG_TO_BIT: work_out[bit_sel] = flags_in[rbf_pkg::FLAG_T];
      rbf_pkg::OP_HALF_CARRY_SET: flags_out[rbf_pkg::FLAG_H] = 1'b1;
      rbf_pkg::OP_HALF_CARRY_CLEAR: flags_out[rbf_pkg::FLAG_H] = 1'b0;
      rbf_pkg::OP_OVERFLOW_SET: flags_out[rbf_pkg::FLAG_V] = 1'b1;
      rbf_pkg::OP_OVERFLOW_CLEAR: flags_out[rbf_pkg::FLAG_V] = 1'b0;
      rbf_pkg::OP_SIGN_FLAG_SET: flags_out[rbf_pkg::FLAG_S] = 1'b1;
      rbf_pkg::OP_SIGN_FLAG_CLEAR: flags_out[rbf_pkg::FLAG_S] = 1'b0;
      rbf_pkg::OP_GLOBAL_IRQ_ENABLE: flags_out[rbf_pkg::FLAG_I] = 1'b1;
      rbf_pkg::OP_GLOBAL_IRQ_DISABLE: flags_out[rbf_pkg::FLAG_I] = 1'b0;
      rbf_pkg::OP_SLEEP: sleep_req = 1'b1;
      rbf_pkg::OP_WATCHDOG_RESTART: watchdog_req = 1'b1;
      default: begin
        // Nop and spare codes change nothing
      end
    endcase
  end
endmodule

//--- test/rbf_top_tb.sv
`timescale 1ns/10ps
module rbf_top_tb;
  logic ref_clk;
  logic rst_n;
  logic [3:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] avs_response;
  logic [7:0] status_flags_register;
  logic sleep_pulse;
  logic watchdog_restart_pulse;
  logic [33:0] exp_q[$];
  int fails;
  int n_compared;
  int cyc;
  int n_sleep;
  int n_dog;

  rbf_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .status_flags_register(status_flags_register), .sleep_pulse(sleep_pulse),
    .watchdog_restart_pulse(watchdog_restart_pulse));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 50 ns period
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Hang guard, far above the roughly 1400 cycles the tests need
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (exp_q.size() != 0) fails = fails + 1;
    if (fails == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Bus master: hold the request until the edge that sees waitrequest low
  task automatic bus_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  // Note the expected {response, data} first; the monitor takes it off
  task automatic bus_read(input logic [3:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
  endtask

  // Monitor: compares read data at the accepting edge, where it stands
  always @(posedge ref_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      n_compared = n_compared + 1;
      if ({avs_response, avs_readdata} !== exp_q[0])
        $display("[FAIL] t=%0t got %h exp %h", $time, {avs_response, avs_readdata}, exp_q[0]);
      if ({avs_response, avs_readdata} !== exp_q[0]) fails = fails + 1;
      void'(exp_q.pop_front());
      if (avs_address == rbf_pkg::ADDR_STATUS && avs_readdata[7:0] !== status_flags_register) begin
        $display("[FAIL] t=%0t flags %h exp %h", $time, status_flags_register, avs_readdata[7:0]);
        fails = fails + 1;
      end
    end
  end

  // Count one-cycle pulses; each sleep or watchdog op issue must give exactly one
  always @(posedge ref_clk) begin
    if (rst_n === 1'b1 && sleep_pulse === 1'b1) n_sleep = n_sleep + 1;
    if (rst_n === 1'b1 && watchdog_restart_pulse === 1'b1) n_dog = n_dog + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reference model, returns {work, flags}; rotates also refresh S as N^V
  function automatic logic [15:0] model(input logic [3:0] op, input logic [2:0] b, input logic [7:0] w,
                                        input logic [7:0] f);
    logic [7:0] r;
    logic [7:0] g;
    r = w;
    g = f;
    if (op == 4'h1 || op == 4'h2) begin
      r = (op == 4'h1) ? {w[6:0], f[0]} : {f[0], w[7:1]};
      g[0] = (op == 4'h1) ? w[7] : w[0];
      g[1] = (r == 8'h00);
      g[2] = r[7];
      g[3] = g[2] ^ g[0];
      g[4] = g[2] ^ g[3];
    end
    case (op)
      4'h3: g[6] = w[b];
      4'h4: r[b] = f[6];
      4'h5: g[5] = 1'b1;
      4'h6: g[5] = 1'b0;
      4'h7: g[3] = 1'b1;
      4'h8: g[3] = 1'b0;
      4'h9: g[4] = 1'b1;
      4'ha: g[4] = 1'b0;
      4'hb: g[7] = 1'b1;
      4'hc: g[7] = 1'b0;
      default: ;
    endcase
    return {r, g};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: every op code with random operands, then refusals
  initial begin
    logic [7:0] f;
    logic [7:0] w;
    logic [2:0] b;
    logic [15:0] m;
    logic [31:0] rnd;
    rst_n = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    fails = 0;
    n_compared = 0;
    cyc = 0;
    n_sleep = 0;
    n_dog = 0;
    m = 16'h0000;
    void'($urandom(57664));
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    bus_read(rbf_pkg::ADDR_STATUS, {26'h0, rbf_pkg::STATUS_RESET});
    bus_read(rbf_pkg::ADDR_WORK, {26'h0, rbf_pkg::WORK_RESET});
    for (int rep = 0; rep < 4; rep++) begin
      for (int o = 0; o < 16; o++) begin
        rnd = $urandom();
        f = rnd[7:0];
        w = rnd[15:8];
        b = rnd[18:16];
        bus_write(rbf_pkg::ADDR_STATUS, {rnd[31:24], 16'h0, f}, 4'hf);
        bus_write(rbf_pkg::ADDR_WORK, {rnd[31:24], 16'h0, w}, 4'hf);
        bus_write(rbf_pkg::ADDR_CMD, {25'h0, b, o[3:0]}, 4'hf);
        m = model(o[3:0], b, w, f);
        bus_read(rbf_pkg::ADDR_STATUS, {26'h0, m[7:0]});
        bus_read(rbf_pkg::ADDR_WORK, {26'h0, m[15:8]});
        bus_read(rbf_pkg::ADDR_EVENTS, {32'h0, o[3:0] == 4'he, o[3:0] == 4'hd});
        bus_write(rbf_pkg::ADDR_EVENTS, 32'h3, 4'hf);
      end
    end
    bus_read(rbf_pkg::ADDR_CMD, 34'h0);
    // Lane 0 off and an unmapped address must both leave the flags alone
    bus_write(rbf_pkg::ADDR_STATUS, 32'h5a, 4'he);
    bus_write(4'h1, 32'ha5, 4'hf);
    bus_read(rbf_pkg::ADDR_STATUS, {26'h0, m[7:0]});
    bus_read(4'h1, {2'b10, 32'h0});
    bus_read(rbf_pkg::ADDR_EVENTS, 34'h0);
    repeat (4) @(posedge ref_clk);
    n_compared = n_compared + 1;
    if (n_sleep != 4 || n_dog != 4) begin
      $display("[FAIL] t=%0t pulses %h %h exp %h %h", $time, n_sleep, n_dog, 4, 4);
      fails = fails + 1;
    end
    give_verdict();
  end
endmodule
